// ### hw/xmac_defs.svh
// constants for the cross-halfword multiply-accumulate unit
`ifndef XMAC_DEFS_SVH
`define XMAC_DEFS_SVH

`define PRIMARY_OPCODE     6'h04
`define EXT_SIGNED_MOD     9'h0AC
`define EXT_SIGNED_SAT     9'h0EC
`define EXT_UNSIGNED_SAT   9'h0CC
`define OPCODE_MSB         31
`define OPCODE_LSB         26
`define OE_BIT             10
`define EXT_MSB            9
`define EXT_LSB            1
`define RECORD_BIT_POS     0
`define MOST_NEGATIVE      32'h80000000
`define MOST_POSITIVE      32'h7FFFFFFF
`define ALL_ONES           32'hFFFFFFFF

`endif

// ### hw/xmac_pkg.sv
// types for the cross-halfword multiply-accumulate unit
package xmac_pkg;

	typedef enum logic [1:0] {
		OP_NONE       = 2'b00,
		OP_SIGNED_MOD = 2'b01,
		OP_SIGNED_SAT = 2'b10,
		OP_UNSIG_SAT  = 2'b11
	} mac_op_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] result;
		logic        record_en;
		logic        ovf_en;
		logic        overflow;
		logic        so_in;
	} mac_stage_t;

	typedef struct packed {
		logic        result_valid;
		logic [31:0] result;
		logic        cond_we;
		logic [3:0]  first_condition_field;
		logic        flags_we;
		logic        overflow_flag;
		logic        summary_overflow;
		logic        illegal;
	} mac_out_t;

endpackage : xmac_pkg

// ### hw/xmac_core.sv
// combinational multiply-add and saturation for one instruction
`timescale 1ns/1ps
`include "xmac_defs.svh"

module xmac_core
	import xmac_pkg::*;
(
	input  wire mac_op_t     op,
	input  wire logic [31:0] first_source_reg,
	input  wire logic [31:0] second_source_reg,
	input  wire logic [31:0] dest_in,
	output      logic [31:0] result,
	output      logic        overflow
);

	logic        is_signed;
	logic [15:0] mul_a;
	logic [15:0] mul_b;
	logic [31:0] prod;
	logic [32:0] temp;
	logic        sat_ovf;

	// low halfword (bits 16:31 msb-0) of first, high halfword of second
	assign mul_a     = first_source_reg[15:0];
	assign mul_b     = second_source_reg[31:16];
	assign is_signed = (op != OP_UNSIG_SAT);

	always_comb begin
		if (is_signed) begin
			prod = 32'($signed(mul_a) * $signed(mul_b));
		end else begin
			prod = 32'(mul_a * mul_b);
		end
	end

	assign temp    = {1'b0, prod} + {1'b0, dest_in};
	// msb-0 temp bit 1 is our bit 31
	assign sat_ovf = (prod[31] == dest_in[31]) && (dest_in[31] != temp[31]);

	always_comb begin
		result   = temp[31:0];
		overflow = 1'b0;
		unique case (op)
			OP_SIGNED_MOD: begin
				overflow = sat_ovf;
			end
			OP_SIGNED_SAT: begin
				overflow = sat_ovf;
				if (sat_ovf) begin
					result = dest_in[31] ? `MOST_NEGATIVE : `MOST_POSITIVE;
				end
			end
			OP_UNSIG_SAT: begin
				overflow = temp[32];
				if (temp[32]) begin
					result = `ALL_ONES;
				end
			end
			OP_NONE: begin
				overflow = 1'b0;
			end
		endcase
	end

endmodule : xmac_core

// ### hw/xmac_unit.sv
// cross-halfword multiply-accumulate execution unit, one-cycle result
//
// Operation
// - opcode 4, extended 172: signed modulo cross-halfword multiply-accumulate.
// - opcode 4, extended 236: signed saturating cross-halfword multiply-accumulate.
// - opcode 4, extended 204: unsigned saturating cross-halfword multiply-accumulate.
// - multiply low halfword of first source by high halfword of second.
// - add 32-bit product to destination into a 33-bit temporary.
// - modulo variant keeps the low 32 bits, carry dropped.
// - signed saturate clamps to most negative or positive on overflow.
// - unsigned saturate forces all ones when the carry is set.
// - record bit set: update less, greater, equal, summary bits of condition field.
// - overflow-enable set: update overflow and summary overflow flags.
`timescale 1ns/1ps
`include "xmac_defs.svh"

module xmac_unit
	import xmac_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        issue_valid,
	input  wire logic [31:0] instr_word,
	input  wire logic [31:0] first_source_reg,
	input  wire logic [31:0] second_source_reg,
	input  wire logic [31:0] dest_in,
	input  wire logic        summary_overflow_in,
	output      logic        result_valid,
	output      logic [31:0] result,
	output      logic        cond_we,
	output      logic [3:0]  first_condition_field,
	output      logic        flags_we,
	output      logic        overflow_flag,
	output      logic        summary_overflow,
	output      logic        illegal
);

	// ----------------------------------------------------------------
	// reset release
	// ----------------------------------------------------------------
	logic rst_meta_reg;
	logic rst_sync_b_reg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_b_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_b_reg <= rst_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	mac_op_t     op;
	logic [5:0]  prim;
	logic [8:0]  ext;
	logic        record_bit;
	logic        ovf_enable;
	logic [31:0] core_result;
	logic        core_ovf;

	assign prim       = instr_word[`OPCODE_MSB:`OPCODE_LSB];
	assign ext        = instr_word[`EXT_MSB:`EXT_LSB];
	assign record_bit = instr_word[`RECORD_BIT_POS];
	assign ovf_enable = instr_word[`OE_BIT];

	always_comb begin
		op = OP_NONE;
		if (prim == `PRIMARY_OPCODE) begin
			if (ext == `EXT_SIGNED_MOD) begin
				op = OP_SIGNED_MOD;
			end else if (ext == `EXT_SIGNED_SAT) begin
				op = OP_SIGNED_SAT;
			end else if (ext == `EXT_UNSIGNED_SAT) begin
				op = OP_UNSIG_SAT;
			end
		end
	end

	xmac_core u_core (
		.op                (op),
		.first_source_reg  (first_source_reg),
		.second_source_reg (second_source_reg),
		.dest_in           (dest_in),
		.result            (core_result),
		.overflow          (core_ovf)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	mac_out_t state_reg;
	mac_out_t state_next;
	logic     so_new;

	// overflow is sticky into summary only when flags are written
	assign so_new = summary_overflow_in | core_ovf;

	always_comb begin
		state_next              = state_reg;
		state_next.result_valid = 1'b0;
		state_next.cond_we      = 1'b0;
		state_next.flags_we     = 1'b0;
		// unknown issue is flagged to decode, never trapped here
		state_next.illegal      = issue_valid && (op == OP_NONE);
		if (issue_valid && (op != OP_NONE)) begin
			state_next.result_valid = 1'b1;
			state_next.result       = core_result;
			state_next.flags_we     = ovf_enable;
			if (ovf_enable) begin
				state_next.overflow_flag    = core_ovf;
				state_next.summary_overflow = so_new;
			end else begin
				state_next.summary_overflow = summary_overflow_in;
			end
			state_next.cond_we = record_bit;
			if (record_bit) begin
				state_next.first_condition_field = {core_result[31],
					!core_result[31] && (core_result != 32'h00000000),
					core_result == 32'h00000000,
					ovf_enable ? so_new : summary_overflow_in};
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_sync_b_reg) begin
		if (!rst_sync_b_reg) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign result_valid          = state_reg.result_valid;
	assign result                = state_reg.result;
	assign cond_we               = state_reg.cond_we;
	assign first_condition_field = state_reg.first_condition_field;
	assign flags_we              = state_reg.flags_we;
	assign overflow_flag         = state_reg.overflow_flag;
	assign summary_overflow      = state_reg.summary_overflow;
	assign illegal               = state_reg.illegal;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence s_issue_op(logic [8:0] code);
		issue_valid && (prim == `PRIMARY_OPCODE) && (ext == code);
	endsequence

	a_signed_mod_wrap: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_SIGNED_MOD) |=> result_valid && (result == $past(dest_in) +
			32'($signed($past(first_source_reg[15:0])) * $signed($past(second_source_reg[31:16])))))
		else $error("signed modulo result wrong");

	a_signed_sat_hi: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_SIGNED_SAT) ##0 (!dest_in[31] && dest_in[30:16] == 15'h7FFF &&
			first_source_reg[15:0] == 16'h7FFF && second_source_reg[31:16] == 16'h7FFF)
		|=> result == `MOST_POSITIVE)
		else $error("signed saturation high clamp missing");

	a_unsig_sat_ones: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_UNSIGNED_SAT) ##0 (dest_in == `ALL_ONES && first_source_reg[15:0] != 16'h0000 &&
			second_source_reg[31:16] != 16'h0000) |=> result == `ALL_ONES &&
			($past(ovf_enable) ? overflow_flag : $stable(overflow_flag)))
		else $error("unsigned saturation wrong");

	a_signed_sat_lo: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_SIGNED_SAT) ##0 (dest_in == `MOST_NEGATIVE && first_source_reg[15:0] == 16'h0001 &&
			second_source_reg[31:16] == 16'hFFFF) |=> result == `MOST_NEGATIVE)
		else $error("signed saturation low clamp missing");

	a_cond_field_eq: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		cond_we |-> first_condition_field[1] == (result == 32'h00000000) && $past(record_bit))
		else $error("condition field equal bit wrong");

	a_flags_write: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		flags_we && overflow_flag |-> summary_overflow)
		else $error("summary overflow not set with overflow");

	a_no_result_bad: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		illegal |-> !result_valid && !cond_we && !flags_we && $stable(result))
		else $error("unknown opcode produced writes");

	a_mod_no_clamp: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_SIGNED_MOD) ##0 (dest_in == `MOST_POSITIVE && first_source_reg[15:0] == 16'h0001 &&
			second_source_reg[31:16] == 16'h0001) |=> result == `MOST_NEGATIVE)
		else $error("modulo variant must wrap");

	// ----------------------------------------------------------------
	// strobe, flag and sign checks
	// ----------------------------------------------------------------
	sequence s_legal_issue;
		issue_valid && (op != OP_NONE);
	endsequence

	a_idle_no_strobe: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		!issue_valid |=> !result_valid && !cond_we && !flags_we && !illegal)
		else $error("strobe without an issue");

	// upper half of the destination zero: no carry is possible
	a_unsig_plain_sum: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_UNSIGNED_SAT) ##0 (dest_in[31:16] == 16'h0000) |=> result ==
			32'($past(first_source_reg[15:0]) * $past(second_source_reg[31:16]) + $past(dest_in)))
		else $error("unsigned sum without carry wrong");

	a_sat_sign_kept: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_issue_op(`EXT_SIGNED_SAT) ##0 (dest_in[31] && first_source_reg[15] != second_source_reg[31])
		|=> result[31])
		else $error("negative sum saturated to positive");

	a_record_lt: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_legal_issue ##0 record_bit |=> cond_we && first_condition_field[3] == result[31])
		else $error("condition field less bit wrong");

	a_ovf_summary: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_legal_issue ##0 ovf_enable |=> flags_we &&
			summary_overflow == ($past(summary_overflow_in) || overflow_flag))
		else $error("summary overflow not the sum of old and new");

	a_ovf_hold: assert property (@(posedge core_clk) disable iff (!rst_sync_b_reg)
		s_legal_issue ##0 !ovf_enable |=> !flags_we && $stable(overflow_flag))
		else $error("overflow flag changed without enable");

endmodule : xmac_unit

// ### verif/test_xmac_unit.sv
// self-checking bench for the cross-halfword multiply-accumulate unit
`timescale 1ns/1ps
`include "xmac_defs.svh"

module test_xmac_unit
	import xmac_pkg::*;
;
	// ------------------------------------------------------------
	// stimulus rows and signals
	// ------------------------------------------------------------
	typedef struct packed {
		logic [8:0]  ext;
		logic        oe;
		logic        rec;
		logic        so;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] d;
	} row_t;

	// carry drop, both clamps, unsigned carry, ignored upper half of a
	row_t        rows [13] = '{
		'{`EXT_SIGNED_MOD, 1'b1, 1'b1, 1'b0, 32'h00000003, 32'h00050000, 32'h0000000A},
		'{`EXT_SIGNED_MOD, 1'b0, 1'b1, 1'b0, 32'h0000FFFF, 32'h00020000, 32'h00000001},
		'{`EXT_SIGNED_MOD, 1'b1, 1'b0, 1'b0, 32'h00007FFF, 32'h7FFF0000, 32'h7FFFFFFF},
		'{`EXT_SIGNED_MOD, 1'b0, 1'b1, 1'b1, 32'h0000FFFF, 32'h00010000, 32'h00000001},
		'{`EXT_SIGNED_SAT, 1'b1, 1'b1, 1'b0, 32'h00007FFF, 32'h7FFF0000, 32'h7FFFFFFF},
		'{`EXT_SIGNED_SAT, 1'b1, 1'b1, 1'b0, 32'h00008000, 32'h7FFF0000, 32'h80000000},
		'{`EXT_SIGNED_SAT, 1'b0, 1'b1, 1'b1, 32'h00000002, 32'hFFFD0000, 32'h00000006},
		'{`EXT_UNSIGNED_SAT, 1'b1, 1'b1, 1'b0, 32'h0000FFFF, 32'hFFFF0000, 32'h00020000},
		'{`EXT_UNSIGNED_SAT, 1'b1, 1'b0, 1'b1, 32'h00008000, 32'h00020000, 32'h00000001},
		'{`EXT_SIGNED_MOD, 1'b0, 1'b0, 1'b1, 32'hABCD0002, 32'h00031234, 32'h00000000},
		'{`EXT_SIGNED_MOD, 1'b1, 1'b1, 1'b0, 32'h00000001, 32'h00010000, 32'h7FFFFFFF},
		'{`EXT_SIGNED_SAT, 1'b1, 1'b1, 1'b0, 32'h00000001, 32'hFFFF0000, 32'h80000000},
		'{`EXT_UNSIGNED_SAT, 1'b0, 1'b1, 1'b0, 32'h00000001, 32'h00010000, 32'hFFFFFFFF}
	};
	logic        core_clk;
	logic        rst_b;
	logic        issue_valid;
	logic [31:0] instr_word;
	logic [31:0] first_source_reg;
	logic [31:0] second_source_reg;
	logic [31:0] dest_in;
	logic        summary_overflow_in;
	logic        result_valid;
	logic [31:0] result;
	logic        cond_we;
	logic [3:0]  first_condition_field;
	logic        flags_we;
	logic        overflow_flag;
	logic        summary_overflow;
	logic        illegal;
	logic [31:0] last_result;
	int          mismatches;
	int          samples_checked;

	xmac_unit xmac_unit_i (
		.core_clk(core_clk), .rst_b(rst_b), .issue_valid(issue_valid), .instr_word(instr_word),
		.first_source_reg(first_source_reg), .second_source_reg(second_source_reg), .dest_in(dest_in),
		.summary_overflow_in(summary_overflow_in), .result_valid(result_valid), .result(result),
		.cond_we(cond_we), .first_condition_field(first_condition_field), .flags_we(flags_we),
		.overflow_flag(overflow_flag), .summary_overflow(summary_overflow), .illegal(illegal)
	);

	// ------------------------------------------------------------
	// reference model and checks
	// ------------------------------------------------------------
	// returns {overflow, result}
	function automatic logic [32:0] ref_mac(input logic [8:0] ext, input logic [31:0] a, b, d);
		logic [31:0] p;
		logic [32:0] t;
		logic        ovf;
		if (ext == `EXT_UNSIGNED_SAT)
			p = a[15:0] * b[31:16];
		else
			p = $signed(a[15:0]) * $signed(b[31:16]);
		t = {1'b0, p} + {1'b0, d};
		ovf = (p[31] == d[31]) && (t[31] != d[31]);
		if (ext == `EXT_UNSIGNED_SAT)
			return {t[32], t[32] ? `ALL_ONES : t[31:0]};
		if (ext == `EXT_SIGNED_SAT && ovf)
			return {1'b1, d[31] ? `MOST_NEGATIVE : `MOST_POSITIVE};
		return {ovf, t[31:0]};
	endfunction : ref_mac

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// issue stays high on return, so calls chain back to back
	task automatic do_op(input logic [5:0] opc, input logic legal, input row_t r);
		logic [32:0] e;
		logic        so_new;
		e = ref_mac(r.ext, r.a, r.b, r.d);
		so_new = r.so | (r.oe & e[32]);
		issue_valid = 1'b1;
		instr_word = {opc, 15'h2A55, r.oe, r.ext, r.rec};
		first_source_reg = r.a;
		second_source_reg = r.b;
		dest_in = r.d;
		summary_overflow_in = r.so;
		@(negedge core_clk);
		chk(32'(illegal), 32'(!legal), "illegal");
		chk(32'(result_valid), 32'(legal), "result_valid");
		chk(32'(cond_we), 32'(legal & r.rec), "cond_we");
		chk(32'(flags_we), 32'(legal & r.oe), "flags_we");
		if (legal) begin
			last_result = e[31:0];
			chk(32'(summary_overflow), 32'(so_new), "summary_overflow");
			if (r.oe)
				chk(32'(overflow_flag), 32'(e[32]), "overflow_flag");
			if (r.rec)
				chk(32'(first_condition_field), 32'({e[31], !e[31] && e[31:0] != 0, e[31:0] == 0, so_new}),
					"condition field");
		end
		chk(result, last_result, "result");
	endtask : do_op

	task automatic report_and_stop;
		$display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// clock, watchdog and sequence
	// ------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	initial begin
		#10000;
		mismatches++;
		report_and_stop();
	end

	initial begin
		rst_b = 1'b0;
		issue_valid = 1'b0;
		instr_word = 32'h00000000;
		first_source_reg = 32'h00000000;
		second_source_reg = 32'h00000000;
		dest_in = 32'h00000000;
		summary_overflow_in = 1'b0;
		last_result = 32'h00000000;
		mismatches = 0;
		samples_checked = 0;
		repeat (10) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(result, 32'h00000000, "result after reset");
		foreach (rows[i])
			do_op(`PRIMARY_OPCODE, 1'b1, rows[i]);
		// unsupported extended code, then wrong primary code: data must hold
		do_op(`PRIMARY_OPCODE, 1'b0, '{9'h08C, 1'b1, 1'b1, 1'b0, 32'h3, 32'h50000, 32'h1});
		do_op(6'h05, 1'b0, rows[0]);
		issue_valid = 1'b0;
		@(negedge core_clk);
		chk(32'(result_valid | cond_we | flags_we | illegal), 32'h0, "strobes after idle cycle");
		chk(result, last_result, "result holds");
		do_op(`PRIMARY_OPCODE, 1'b1, rows[4]);
		issue_valid = 1'b0;
		// reset in mid-run clears outputs at once, without a clock edge
		rst_b = 1'b0;
		#1;
		chk(result, 32'h00000000, "result during reset");
		chk(32'({result_valid, cond_we, flags_we, illegal, overflow_flag, summary_overflow, first_condition_field}),
			32'h0, "flags during reset");
		@(negedge core_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge core_clk);
		last_result = 32'h00000000;
		do_op(`PRIMARY_OPCODE, 1'b1, rows[7]);
		issue_valid = 1'b0;
		@(negedge core_clk);
		report_and_stop();
	end

endmodule : test_xmac_unit
